// >>> verilog/gss_pkg.sv
// package for the generator set start/stop sequencer
// assumes a 25 MHz core clock; all times are counted on a one-second tick
package gss_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int TICK_CYCLES = CLK_HZ;
   localparam int STOP_HOLD_S = 5;
   localparam int SEC_LEVEL_REPROG = 3;
   localparam logic [7:0] CRANK_TIME_RST = 8'h0A;
   localparam logic [7:0] COOLDOWN_MIN_RST = 8'h00;
   localparam int SEC_PER_MIN = 60;

   typedef enum logic [1:0] {
      GSS_MODE_OFF,
      GSS_MODE_MANUAL,
      GSS_MODE_AUTO
   } gss_mode_t;

   typedef struct packed {
      logic runKey;
      logic stopKey;
      logic okKey;
      logic escKey;
   } gss_keys_t;

   typedef struct packed {
      logic ecsAuto;
      logic ecsRun;
      logic ecsStop;
      logic remoteStartN;
      logic modbusInitiate;
      logic cycleTimer;
   } gss_remote_t;

   typedef struct packed {
      logic shutdownPresent;
      logic shutdownLatched;
      logic preCrankDone;
   } gss_status_t;

   typedef struct packed {
      logic ecmCrank;
      logic oilSensorCfg;
      logic coolSensorCfg;
      logic [2:0] securityLevel;
      logic [7:0] crankTimeS;
      logic [15:0] crankTermRpm;
      logic [7:0] cooldownMin;
   } gss_cfg_t;

   typedef struct packed {
      logic oilDlActive;
      logic oilIdleActive;
      logic coolDlActive;
      logic coolAinActive;
      logic ain2ProgAllow;
   } gss_prot_t;

   typedef struct packed {
      logic valid;
      logic fromDataLink;
      logic [3:0] code;
   } gss_event_t;
endpackage

// >>> verilog/gss_sequencer.sv
// generator set start, crank, cooldown and stop sequencer
// assumes all inputs synchronous to core_clk; relays and CAN frames driven outside
// Functional notes
// - sensor oil configuration disables the data-link oil pressure setpoints other than the low-idle ones.
// - low-idle oil pressure warning and shutdown stay active in both configurations.
// - sensor coolant uses analog input two; data-link coolant setpoints ignored.
// - analog input two reprogramming from panel needs security level three or more.
// - start from run key (manual only) or control switch run; auto adds remote sources.
// - refuse cranking while any shutdown event is present or latched.
// - after pre-crank finishes, assert starter and fuel enable outputs.
// - starter holds until crank time expires or terminate speed reached.
// - with ECM command interface, start and fuel go over CAN; relays freed.
// - with ECM cranking, own crank time and terminate speed are not applied.
// - active control switch input makes front panel operating keys ignored; the stop key hold in cooldown is still read.
// - remote start active requests start; release requests stop.
// - remote start input is active low.
// - stop on stop key or switch stop; auto stops when all initiates drop.
// - on stop, cool down for programmed duration before stopping.
// - zero cooldown duration stops the engine immediately.
// - cooldown set to zero when ECM runs its own cooldown.
// - stop key held five seconds in cooldown raises bypass prompt.
// - protection events logged with the source module that raised them.
// - at prompt confirm ends cooldown, cancel lets it run out.
// - cooldown end drops fuel and sends a CAN stop where required.
`timescale 1ns/10ps
module gss_sequencer
   import gss_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire gss_mode_t mode,
   input wire gss_keys_t keys,
   input wire gss_remote_t remote,
   input wire gss_status_t status,
   input wire logic [15:0] engineRpm,
   input wire logic protEventIn,
   input wire logic protEventFromDl,
   input wire logic [3:0] protEventCode,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic starterOut,
   output logic fuelOut,
   output logic canStartCmd,
   output logic canFuelCmd,
   output logic canStopCmd,
   output logic bypassPrompt,
   output logic running,
   output gss_prot_t prot,
   output gss_event_t eventLog
);

   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_CRANK = 4'h1;
   localparam logic [3:0] REG_COOL = 4'h2;
   localparam logic [3:0] REG_STATE = 4'h3;

   typedef enum logic [2:0] {
      GSS_IDLE,
      GSS_PRECRANK,
      GSS_CRANK,
      GSS_RUN,
      GSS_COOLDOWN
   } gss_state_t;

   gss_state_t state;
   gss_cfg_t cfg;
   logic [24:0] tickCnt;
   logic tick;
   logic [15:0] secCnt;
   logic [2:0] holdCnt;
   logic panelOk;
   logic autoInit;
   logic startReq;
   logic stopReq;
   logic remoteActive;
   logic prevRemote;
   logic [15:0] coolLimit;

   function automatic logic [15:0] min_to_sec(input logic [7:0] m);
      min_to_sec = 16'(m) * 16'(SEC_PER_MIN);
   endfunction

   // fuel stays on from crank until cooldown ends or is bypassed
   function automatic logic in_fuel_phase(input gss_state_t s);
      in_fuel_phase = (s == GSS_CRANK) || (s == GSS_RUN) || (s == GSS_COOLDOWN);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // request decode
   always_comb begin
      remoteActive = ~remote.remoteStartN;
      // a maintained switch input owns the panel
      panelOk = ~(remote.ecsAuto | remote.ecsRun | remote.ecsStop);
      autoInit = remoteActive | remote.modbusInitiate | remote.cycleTimer;
      startReq = (panelOk & keys.runKey & (mode == GSS_MODE_MANUAL)) | remote.ecsRun
         | ((mode == GSS_MODE_AUTO) & autoInit);
      stopReq = (panelOk & keys.stopKey) | remote.ecsStop
         | ((mode == GSS_MODE_AUTO) & ~autoInit)
         | ((mode == GSS_MODE_AUTO) & prevRemote & ~remoteActive);
      coolLimit = min_to_sec(cfg.cooldownMin);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prevRemote <= 1'b0;
      end else begin
         prevRemote <= remoteActive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // one-second tick
   // free running from reset, so an interval may end up to one tick early
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tickCnt <= '0;
         tick <= 1'b0;
      end else if (tickCnt == 25'(TICK_DIV - 1)) begin
         tickCnt <= '0;
         tick <= 1'b1;
      end else begin
         tickCnt <= tickCnt + 25'h0000001;
         tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= '{ecmCrank: 1'b0, oilSensorCfg: 1'b1, coolSensorCfg: 1'b1,
                  securityLevel: 3'h0, crankTimeS: CRANK_TIME_RST,
                  crankTermRpm: 16'h012C, cooldownMin: COOLDOWN_MIN_RST};
      end else if (regWr) begin
         case (regAddr)
            REG_CFG: begin
               cfg.ecmCrank <= regWdata[0];
               cfg.oilSensorCfg <= regWdata[1];
               cfg.coolSensorCfg <= regWdata[2];
               cfg.securityLevel <= regWdata[6:4];
            end
            REG_CRANK: begin
               cfg.crankTimeS <= regWdata[7:0];
               cfg.crankTermRpm <= regWdata[31:16];
            end
            // zero when the ECM runs its own cooldown, else both run in series
            REG_COOL: cfg.cooldownMin <= regWdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         regRdata <= 32'h00000000;
      end else if (regRd) begin
         case (regAddr)
            REG_CFG: regRdata <= {25'h0, cfg.securityLevel, 1'b0, cfg.coolSensorCfg,
                                  cfg.oilSensorCfg, cfg.ecmCrank};
            REG_CRANK: regRdata <= {cfg.crankTermRpm, 8'h00, cfg.crankTimeS};
            REG_COOL: regRdata <= {24'h0, cfg.cooldownMin};
            REG_STATE: regRdata <= {16'(secCnt), 8'h00, bypassPrompt, running,
                                    3'(state), 1'b0, fuelOut, starterOut};
            default: regRdata <= 32'h00000000;
         endcase
      end else begin
         regRdata <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // protection setpoint selection
   // flags other than the idle oil flag follow the configuration one cycle late; no other state involved
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prot.oilDlActive <= 1'b0;
      end else begin
         prot.oilDlActive <= ~cfg.oilSensorCfg;
      end
   end

   // idle setpoints never depend on the sensor source
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prot.oilIdleActive <= 1'b0;
      end else begin
         prot.oilIdleActive <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prot.coolDlActive <= 1'b0;
      end else begin
         prot.coolDlActive <= ~cfg.coolSensorCfg;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prot.coolAinActive <= 1'b0;
      end else begin
         prot.coolAinActive <= cfg.coolSensorCfg;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prot.ain2ProgAllow <= 1'b0;
      end else begin
         prot.ain2ProgAllow <= (cfg.securityLevel >= 3'(SEC_LEVEL_REPROG));
      end
   end

   // pass-through only: storage and readout belong to the event handler
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         eventLog.valid <= 1'b0;
      end else begin
         eventLog.valid <= protEventIn;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         eventLog.fromDataLink <= 1'b0;
      end else begin
         eventLog.fromDataLink <= protEventFromDl;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         eventLog.code <= 4'h0;
      end else begin
         eventLog.code <= protEventCode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= GSS_IDLE;
         secCnt <= '0;
         holdCnt <= '0;
         bypassPrompt <= 1'b0;
      end else begin
         case (state)
            GSS_IDLE: begin
               bypassPrompt <= 1'b0;
               if (startReq && !status.shutdownPresent && !status.shutdownLatched) begin
                  state <= GSS_PRECRANK;
               end
            end
            GSS_PRECRANK: begin
               secCnt <= '0;
               if (status.shutdownPresent || status.shutdownLatched) begin
                  state <= GSS_IDLE;
               end else if (status.preCrankDone) begin
                  state <= GSS_CRANK;
               end
            end
            GSS_CRANK: begin
               if (tick) begin
                  secCnt <= secCnt + 16'h0001;
               end
               // ECM runs its own crank limits; hand over straight away
               if (cfg.ecmCrank) begin
                  state <= GSS_RUN;
               end else if (engineRpm >= cfg.crankTermRpm) begin
                  state <= GSS_RUN;
               end else if (tick && secCnt + 16'h0001 >= 16'(cfg.crankTimeS)) begin
                  state <= GSS_IDLE;
               end
            end
            GSS_RUN: begin
               secCnt <= '0;
               holdCnt <= '0;
               if (stopReq) begin
                  state <= (cfg.cooldownMin == 8'h00) ? GSS_IDLE : GSS_COOLDOWN;
               end
            end
            GSS_COOLDOWN: begin
               if (tick) begin
                  secCnt <= secCnt + 16'h0001;
               end
               if (!keys.stopKey) begin
                  holdCnt <= '0;
               end else if (tick && holdCnt != 3'(STOP_HOLD_S)) begin
                  holdCnt <= holdCnt + 3'h1;
               end
               if (holdCnt == 3'(STOP_HOLD_S)) begin
                  bypassPrompt <= 1'b1;
               end
               if (bypassPrompt && keys.okKey) begin
                  state <= GSS_IDLE;
                  bypassPrompt <= 1'b0;
               end else if (bypassPrompt && keys.escKey) begin
                  bypassPrompt <= 1'b0;
                  holdCnt <= '0;
               end
               if (secCnt >= coolLimit) begin
                  state <= GSS_IDLE;
                  bypassPrompt <= 1'b0;
               end
            end
            default: state <= GSS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // every command is registered so a configuration write cannot glitch a relay
   // relays freed when the ECM takes commands over CAN
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         starterOut <= 1'b0;
      end else begin
         starterOut <= (state == GSS_CRANK) & ~cfg.ecmCrank;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fuelOut <= 1'b0;
      end else begin
         fuelOut <= in_fuel_phase(state) & ~cfg.ecmCrank;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         canStartCmd <= 1'b0;
      end else begin
         canStartCmd <= (state == GSS_CRANK) & cfg.ecmCrank;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         canFuelCmd <= 1'b0;
      end else begin
         canFuelCmd <= in_fuel_phase(state) & cfg.ecmCrank;
      end
   end

   // one-cycle stop frame on the edge where the CAN fuel command drops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         canStopCmd <= 1'b0;
      end else begin
         canStopCmd <= cfg.ecmCrank & (state == GSS_IDLE) & canFuelCmd;
      end
   end

   // running covers cooldown too, since the engine still turns there
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         running <= 1'b0;
      end else begin
         running <= (state == GSS_RUN || state == GSS_COOLDOWN);
      end
   end

endmodule

// >>> verification/gss_sequencer_properties.sv
// port checker for the start/stop sequencer
// assumes one core_clk domain and binding to every gss_sequencer
`timescale 1ns/10ps
module gss_sequencer_properties
   import gss_pkg::*;
#(
   parameter int TICK_DIV = 10
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire gss_keys_t keys,
   input wire gss_status_t status,
   input wire logic protEventIn,
   input wire logic protEventFromDl,
   input wire logic [3:0] protEventCode,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire logic starterOut,
   input wire logic fuelOut,
   input wire logic canStartCmd,
   input wire logic canFuelCmd,
   input wire logic canStopCmd,
   input wire logic bypassPrompt,
   input wire logic running,
   input wire gss_prot_t prot,
   input wire gss_event_t eventLog
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////
   sequence s_promptGone;
      bypassPrompt ##1 !bypassPrompt;
   endsequence
   AST_CRANK_FUEL: assert property ($rose(starterOut) |-> fuelOut)
      else $error("starter raised without fuel");
   AST_ECM_RELAYS: assert property (canStartCmd || canFuelCmd |-> !starterOut && !fuelOut)
      else $error("relays driven in ecm mode");
   AST_SHUT_HOLD: assert property ((status.shutdownPresent || status.shutdownLatched)
      && !running && !starterOut |=> !starterOut)
      else $error("cranking with shutdown");
   AST_IDLE_OIL: assert property ($past(nrst) |-> prot.oilIdleActive)
      else $error("idle oil setpoints inactive");
   AST_COOL_SRC: assert property ($past(nrst) |-> prot.coolAinActive != prot.coolDlActive)
      else $error("coolant source ambiguous");
   AST_EVT_LOG: assert property (protEventIn |=> eventLog.valid
      && eventLog.fromDataLink == $past(protEventFromDl) && eventLog.code == $past(protEventCode))
      else $error("event log mismatch");
   AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside slot");
   AST_STOP_PULSE: assert property (canStopCmd |-> !canFuelCmd ##1 !canStopCmd)
      else $error("can stop not a pulse");
   AST_PROMPT: assert property ($rose(bypassPrompt) |-> $past(keys.stopKey) && running)
      else $error("prompt without stop key");
   AST_PROMPT_END: assert property (s_promptGone |-> ($past(keys.escKey) or (##1 !running)))
      else $error("prompt cleared wrongly");
endmodule

bind gss_sequencer gss_sequencer_properties #(.TICK_DIV(TICK_DIV)) u_props (.core_clk, .nrst,
   .keys, .status, .protEventIn, .protEventFromDl, .protEventCode, .regRd, .regRdata,
   .starterOut, .fuelOut, .canStartCmd, .canFuelCmd, .canStopCmd, .bypassPrompt, .running,
   .prot, .eventLog);

// >>> verification/gss_engine_model.sv
// engine model: speed climbs while cranked and fuelled
// assumes crankOn and fuelOn come from relays or ecm commands
`timescale 1ns/10ps
module gss_engine_model #(
   parameter int RPM_STEP = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic crankOn,
   input wire logic fuelOn,
   input wire logic spin,
   output logic [15:0] engineRpm
);
   // spin low models an engine that never catches
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         engineRpm <= 16'h0000;
      end else if (!fuelOn) begin
         engineRpm <= 16'h0000;
      end else if (crankOn && spin) begin
         engineRpm <= engineRpm + 16'(RPM_STEP);
      end
   end
endmodule

// >>> verification/gss_sequencer_tb.sv
// testbench for the start/stop sequencer
// assumes a short tick divider so minutes fit the run
`timescale 1ns/10ps
module gss_sequencer_tb;
   import gss_pkg::*;
   localparam int TD = 10;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   gss_mode_t mode = GSS_MODE_OFF;
   gss_keys_t keys = '0;
   gss_remote_t remote = 6'h04;
   gss_status_t status = 3'h1;
   logic [15:0] engineRpm;
   logic protEventIn = 1'b0, protEventFromDl = 1'b0, spin = 1'b1;
   logic [3:0] protEventCode = 4'h0, regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0, regRdata;
   logic regWr = 1'b0, regRd = 1'b0;
   logic starterOut, fuelOut, canStartCmd, canFuelCmd, canStopCmd, bypassPrompt, running;
   gss_prot_t prot;
   gss_event_t eventLog;
   logic [4:0] obs;
   int n_mismatch = 0;
   int check_count = 0;
   logic [31:0] cfgs [4] = '{32'h36, 32'h00, 32'h34, 32'h22};
   logic [4:0] prots [4] = '{5'h0B, 5'h1C, 5'h1B, 5'h0C};
   assign obs = {canStopCmd, bypassPrompt, canFuelCmd, running, starterOut};
   always #20 core_clk = ~core_clk;
   gss_sequencer #(.TICK_DIV(TD)) dut (.core_clk, .nrst, .mode, .keys, .remote, .status,
      .engineRpm, .protEventIn, .protEventFromDl, .protEventCode, .regAddr, .regWdata, .regWr,
      .regRd, .regRdata, .starterOut, .fuelOut, .canStartCmd, .canFuelCmd, .canStopCmd,
      .bypassPrompt, .running, .prot, .eventLog);
   gss_engine_model eng (.core_clk, .nrst, .crankOn(starterOut | canStartCmd),
      .fuelOn(fuelOut | canFuelCmd), .spin, .engineRpm);
   ////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      step(1);
      regWr <= 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      step(1);
      regRd <= 1'b0;
      @(negedge core_clk);
      chk("regRdata", e, regRdata);
      step(1);
   endtask
   // ends at a falling edge so the caller reads settled outputs
   task automatic wt(input int w, input logic v, input string nm, input int lim);
      int i;
      i = 0;
      @(negedge core_clk);
      while (obs[w] !== v && i < lim) begin
         @(negedge core_clk);
         i++;
      end
      if (i == lim) begin
         chk(nm, 32'(v), 32'(obs[w]));
         results();
      end
   endtask
   task automatic press(input int k);
      keys[k] <= 1'b1;
      step(2);
      keys[k] <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      step(3);
      nrst <= 1'b1;
      step(1);
      rd(4'h0, 32'h00000006);
      rd(4'h1, 32'h012C000A);
      rd(4'hF, 32'h0);
      chk("prot", 32'h0A, 32'(prot));
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, cfgs[i]);
         step(2);
         chk("prot", 32'(prots[i]), 32'(prot));
      end
      wr(4'h0, 32'h06);
      wr(4'h1, 32'h00640003);
      wr(4'h2, 32'h0);
      mode <= GSS_MODE_MANUAL;
      for (int i = 0; i < 2; i++) begin
         status <= i ? 3'h5 : 3'h3;
         press(3);
         step(20);
         chk("starter", 0, starterOut);
      end
      status <= 3'h1;
      remote <= 6'h0C;
      press(3);
      step(20);
      chk("starter", 0, starterOut);
      remote <= 6'h04;
      press(3);
      wt(0, 1'b1, "starter", 40);
      chk("fuel", 1, fuelOut);
      wt(0, 1'b0, "starter", 40);
      chk("rpm", 1, engineRpm >= 16'h0064);
      chk("running", 1, running);
      step(1);
      press(2);
      wt(1, 1'b0, "running", 4);
      chk("fuel", 0, fuelOut);
      step(1);
      spin <= 1'b0;
      remote <= 6'h14;
      wt(0, 1'b1, "starter", 40);
      step(1);
      remote <= 6'h04;
      repeat (2 * TD - 2) @(negedge core_clk);
      chk("starter", 1, starterOut);
      wt(0, 1'b0, "starter", 2 * TD + 4);
      chk("running", 0, running);
      step(1);
      spin <= 1'b1;
      wr(4'h2, 32'h1);
      mode <= GSS_MODE_AUTO;
      remote <= 6'h00;
      wt(1, 1'b1, "running", 200);
      wt(0, 1'b0, "starter", 40);
      step(1);
      remote <= 6'h04;
      step(2 * TD);
      chk("running", 1, running);
      keys.stopKey <= 1'b1;
      wt(3, 1'b1, "prompt", 7 * TD);
      step(1);
      keys.stopKey <= 1'b0;
      step(1);
      press(0);
      wt(3, 1'b0, "prompt", 4);
      chk("running", 1, running);
      step(1);
      keys.stopKey <= 1'b1;
      wt(3, 1'b1, "prompt", 7 * TD);
      step(1);
      keys.stopKey <= 1'b0;
      step(1);
      press(1);
      wt(1, 1'b0, "running", 4);
      chk("fuel", 0, fuelOut);
      step(1);
      wr(4'h2, 32'h0);
      wr(4'h0, 32'h07);
      spin <= 1'b0;
      remote <= 6'h06;
      wt(2, 1'b1, "canFuel", 50);
      chk("relays", 0, {starterOut, fuelOut});
      repeat (5 * TD) @(negedge core_clk);
      chk("running", 1, running);
      step(1);
      remote <= 6'h04;
      wt(4, 1'b1, "canStop", 50);
      step(1);
      remote <= 6'h05;
      wt(1, 1'b1, "running", 50);
      step(1);
      remote <= 6'h04;
      wt(1, 1'b0, "running", 50);
      step(1);
      for (int i = 0; i < 2; i++) begin
         protEventIn <= 1'b1;
         protEventFromDl <= !i;
         protEventCode <= i ? 4'hA : 4'h5;
         step(1);
         protEventIn <= 1'b0;
         @(negedge core_clk);
         chk("eventLog", i ? 32'h2A : 32'h35, 32'(eventLog));
         step(1);
      end
      results();
   end
endmodule
